// File: logic/pas_pkg.sv
// Constants for the port analog select block.
// Assumes an AXI4-Lite master with 32-bit data on the system clock.
// How it works
// - Each of the four low port A select bits, when one, turns that pin's digital input buffer off.
// - Port A select bits 15 to 4 do not exist and read as zero.
// - Port B select bits 15 to 12 turn their buffers off when one, and bits 11 to 5 read as zero.
// - Port B select bits 4 to 0 turn their buffers off when one and leave them on when zero.
// - On the 14-pin package, port B select bits 13, 12, 2, 1 and 0 do not exist.
// - On the 14-pin and 20-pin packages, port B select bit 3 does not exist.
package pas_pkg;
	localparam int PAS_ADDR_W = 4;
	localparam logic [PAS_ADDR_W-1:0] PAS_OFS_PORT_A = 4'h0;
	localparam logic [PAS_ADDR_W-1:0] PAS_OFS_PORT_B = 4'h4;
	localparam logic [15:0] PAS_MASK_A = 16'h000F;
	localparam logic [15:0] PAS_MASK_B_FULL = 16'hF01F;
	localparam logic [15:0] PAS_DROP_B_14 = 16'h3007;
	localparam logic [15:0] PAS_DROP_B_20 = 16'h0008;
	localparam logic [15:0] PAS_RESET_SEL = 16'hFFFF;
	localparam logic [1:0] PAS_RESP_OKAY = 2'h0;
	localparam logic [1:0] PAS_RESP_SLVERR = 2'h2;
	localparam int PAS_PINS_14 = 14;
	localparam int PAS_PINS_20 = 20;
	localparam int PAS_PINS_28 = 28;
endpackage : pas_pkg

// File: logic/pas_sel_reg.sv
// One 16-bit analog select register with an implemented-bit mask.
// Assumes write strobes from the bus slave on the same clock.
`timescale 1ns/1ps
module pas_sel_reg import pas_pkg::*; #(
	parameter logic [15:0] IMPL_MASK = 16'h000F
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic wr_in,
	input wire logic [1:0] strb_in,
	input wire logic [15:0] data_in,
	output logic [15:0] sel_out
);
	typedef struct packed {
		logic [15:0] sel;
	} pas_reg_t;
	pas_reg_t st_q;
	pas_reg_t st_d;
	always_comb begin
		st_d = st_q;
		if (wr_in) begin
			if (strb_in[0])
				st_d.sel[7:0] = data_in[7:0];
			if (strb_in[1])
				st_d.sel[15:8] = data_in[15:8];
		end
		st_d.sel = st_d.sel & IMPL_MASK;
	end
	always_ff @(posedge clk_in) begin
		if (rst_in)
			st_q.sel <= PAS_RESET_SEL & IMPL_MASK;
		else
			st_q <= st_d;
	end
	assign sel_out = st_q.sel;
	unused_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(sel_out & ~IMPL_MASK) == 16'h0000)
		else $error("unimplemented select bit set");
	reset_ones_a: assert property (@(posedge clk_in) $past(rst_in) |-> sel_out == IMPL_MASK)
		else $error("select not all ones after reset");
	write_low_a: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_in && strb_in[0] |=> sel_out[7:0] == ($past(data_in[7:0]) & IMPL_MASK[7:0]))
		else $error("low byte write lost");
	write_high_a: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_in && strb_in[1] |=> sel_out[15:8] == ($past(data_in[15:8]) & IMPL_MASK[15:8]))
		else $error("high byte write lost");
	hold_value_a: assert property (@(posedge clk_in) disable iff (rst_in)
		!wr_in |=> $stable(sel_out))
		else $error("select changed without write");
	cover_clear_c: cover property (@(posedge clk_in) disable iff (rst_in) wr_in && data_in == 16'h0000);
endmodule : pas_sel_reg

// File: logic/pas_top.sv
// Port analog select block: two select registers behind an AXI4-Lite slave.
// Assumes one write and one read at most in flight; PIN_COUNT picks the package.
`timescale 1ns/1ps
module pas_top import pas_pkg::*; #(
	parameter int PIN_COUNT = PAS_PINS_28
) (
	input wire logic SYS_CLK_IN,
	input wire logic RST_IN,
	input wire logic [PAS_ADDR_W-1:0] S_AXI_AWADDR_IN,
	input wire logic S_AXI_AWVALID_IN,
	output logic S_AXI_AWREADY_OUT,
	input wire logic [31:0] S_AXI_WDATA_IN,
	input wire logic [3:0] S_AXI_WSTRB_IN,
	input wire logic S_AXI_WVALID_IN,
	output logic S_AXI_WREADY_OUT,
	output logic [1:0] S_AXI_BRESP_OUT,
	output logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	input wire logic [PAS_ADDR_W-1:0] S_AXI_ARADDR_IN,
	input wire logic S_AXI_ARVALID_IN,
	output logic S_AXI_ARREADY_OUT,
	output logic [31:0] S_AXI_RDATA_OUT,
	output logic [1:0] S_AXI_RRESP_OUT,
	output logic S_AXI_RVALID_OUT,
	input wire logic S_AXI_RREADY_IN,
	output logic [15:0] PORT_A_BUF_OFF_OUT,
	output logic [15:0] PORT_B_BUF_OFF_OUT
);
	// ****************************************
	// Package variant masks
	// ****************************************
	localparam logic [15:0] MASK_B = (PIN_COUNT == PAS_PINS_14) ?
		(PAS_MASK_B_FULL & ~PAS_DROP_B_14 & ~PAS_DROP_B_20) :
		(PIN_COUNT == PAS_PINS_20) ? (PAS_MASK_B_FULL & ~PAS_DROP_B_20) :
		PAS_MASK_B_FULL;
	// Only the three package variants have a defined pin set
	if (PIN_COUNT != PAS_PINS_14 && PIN_COUNT != PAS_PINS_20
		&& PIN_COUNT != PAS_PINS_28) begin : g_bad_pins
		$error("PIN_COUNT must be 14, 20 or 28");
	end
	// ****************************************
	// Bus slave state
	// ****************************************
	typedef struct packed {
		logic aw_got;
		logic [PAS_ADDR_W-1:0] aw_addr;
		logic awready;
		logic w_got;
		logic wready;
		logic [15:0] w_data;
		logic [1:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [15:0] pin_a;
		logic [15:0] pin_b;
	} pas_state_t;
	pas_state_t st_q;
	pas_state_t st_d;
	logic [15:0] sel_a;
	logic [15:0] sel_b;
	logic do_wr;
	logic wr_a;
	logic wr_b;
	assign do_wr = st_q.aw_got && st_q.w_got && !st_q.bvalid;
	assign wr_a = do_wr && st_q.aw_addr == PAS_OFS_PORT_A;
	assign wr_b = do_wr && st_q.aw_addr == PAS_OFS_PORT_B;
	// ****************************************
	// Write and read handshakes
	// ****************************************
	always_comb begin
		st_d = st_q;
		st_d.arready = 1'b0;
		// Address and data may arrive in either order
		if (S_AXI_AWVALID_IN && !st_q.aw_got) begin
			st_d.aw_got = 1'b1;
			st_d.aw_addr = S_AXI_AWADDR_IN;
		end
		if (S_AXI_WVALID_IN && !st_q.w_got) begin
			st_d.w_got = 1'b1;
			st_d.w_data = S_AXI_WDATA_IN[15:0];
			st_d.w_strb = S_AXI_WSTRB_IN[1:0];
		end
		// Response only once both halves are held
		if (do_wr) begin
			st_d.aw_got = 1'b0;
			st_d.w_got = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = (wr_a || wr_b) ? PAS_RESP_OKAY : PAS_RESP_SLVERR;
		end
		if (st_q.bvalid && S_AXI_BREADY_IN)
			st_d.bvalid = 1'b0;
		// Read data is captured as the address is seen
		if (S_AXI_ARVALID_IN && !st_q.arready && !st_q.rvalid) begin
			st_d.arready = 1'b1;
			st_d.rvalid = 1'b1;
			st_d.rresp = PAS_RESP_OKAY;
			unique case (S_AXI_ARADDR_IN)
				PAS_OFS_PORT_A: st_d.rdata = {16'h0000, sel_a};
				PAS_OFS_PORT_B: st_d.rdata = {16'h0000, sel_b};
				default: begin
					st_d.rdata = 32'h0000_0000;
					st_d.rresp = PAS_RESP_SLVERR;
				end
			endcase
		end
		if (st_q.rvalid && S_AXI_RREADY_IN)
			st_d.rvalid = 1'b0;
		// Pins lag the registers by one cycle
		st_d.pin_a = sel_a;
		st_d.pin_b = sel_b;
		st_d.awready = !st_d.aw_got;
		st_d.wready = !st_d.w_got;
	end
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			st_q <= '0;
			// Both write channels ready straight out of reset
			st_q.awready <= 1'b1;
			st_q.wready <= 1'b1;
			st_q.pin_a <= PAS_RESET_SEL & PAS_MASK_A;
			st_q.pin_b <= PAS_RESET_SEL & MASK_B;
		end else begin
			st_q <= st_d;
		end
	end
	// ****************************************
	// Select registers
	// ****************************************
	pas_sel_reg #(.IMPL_MASK(PAS_MASK_A)) u_port_a (
		.clk_in(SYS_CLK_IN),
		.rst_in(RST_IN),
		.wr_in(wr_a),
		.strb_in(st_q.w_strb),
		.data_in(st_q.w_data),
		.sel_out(sel_a)
	);
	pas_sel_reg #(.IMPL_MASK(MASK_B)) u_port_b (
		.clk_in(SYS_CLK_IN),
		.rst_in(RST_IN),
		.wr_in(wr_b),
		.strb_in(st_q.w_strb),
		.data_in(st_q.w_data),
		.sel_out(sel_b)
	);
	// ****************************************
	// Bus and pin outputs
	// ****************************************
	assign S_AXI_AWREADY_OUT = st_q.awready;
	assign S_AXI_WREADY_OUT = st_q.wready;
	assign S_AXI_BVALID_OUT = st_q.bvalid;
	assign S_AXI_BRESP_OUT = st_q.bresp;
	assign S_AXI_ARREADY_OUT = st_q.arready;
	assign S_AXI_RVALID_OUT = st_q.rvalid;
	assign S_AXI_RDATA_OUT = st_q.rdata;
	assign S_AXI_RRESP_OUT = st_q.rresp;
	assign PORT_A_BUF_OFF_OUT = st_q.pin_a;
	assign PORT_B_BUF_OFF_OUT = st_q.pin_b;
	// ****************************************
	// Checks
	// ****************************************
	pin_a_follow_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		##1 PORT_A_BUF_OFF_OUT == $past(sel_a))
		else $error("port A buffer control does not follow select");
	pin_b_follow_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		##1 PORT_B_BUF_OFF_OUT == $past(sel_b))
		else $error("port B buffer control does not follow select");
	pin_a_upper_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		PORT_A_BUF_OFF_OUT[15:4] == 12'h000)
		else $error("port A unimplemented pin driven");
	pin_b_mask_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(PORT_B_BUF_OFF_OUT & ~MASK_B) == 16'h0000)
		else $error("port B missing pin driven");
	read_a_data_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT == 1'b0 && !S_AXI_RVALID_OUT
		&& S_AXI_ARADDR_IN == PAS_OFS_PORT_A |=> S_AXI_RDATA_OUT == {16'h0000, $past(sel_a)})
		else $error("port A read data wrong");
	read_b_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT == 1'b0 && !S_AXI_RVALID_OUT
		&& S_AXI_ARADDR_IN == PAS_OFS_PORT_B |=> S_AXI_RDATA_OUT == {16'h0000, $past(sel_b)})
		else $error("port B read data wrong");
	read_bad_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		S_AXI_ARVALID_IN && !S_AXI_ARREADY_OUT && !S_AXI_RVALID_OUT
		&& S_AXI_ARADDR_IN != PAS_OFS_PORT_A && S_AXI_ARADDR_IN != PAS_OFS_PORT_B
		|=> S_AXI_RRESP_OUT == PAS_RESP_SLVERR && S_AXI_RDATA_OUT == 32'h0000_0000)
		else $error("unmapped read not refused");
	reset_pins_a: assert property (@(posedge SYS_CLK_IN)
		$past(RST_IN) && RST_IN |-> PORT_A_BUF_OFF_OUT == PAS_MASK_A
		&& PORT_B_BUF_OFF_OUT == MASK_B)
		else $error("pins not analog in reset");
	write_resp_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		do_wr |=> S_AXI_BVALID_OUT)
		else $error("write response missing");
	write_bad_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		do_wr && !wr_a && !wr_b |=> S_AXI_BRESP_OUT == PAS_RESP_SLVERR)
		else $error("unmapped write not refused");
	bresp_done_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		S_AXI_BVALID_OUT && S_AXI_BREADY_IN |=> !S_AXI_BVALID_OUT)
		else $error("write response not retired");
	rdata_done_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		S_AXI_RVALID_OUT && S_AXI_RREADY_IN |=> !S_AXI_RVALID_OUT)
		else $error("read data not retired");
	read_resp_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		S_AXI_ARREADY_OUT |-> S_AXI_RVALID_OUT)
		else $error("read taken without data");
	write_pin_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		wr_b && st_q.w_strb == 2'h3 |=> ##1
		PORT_B_BUF_OFF_OUT == ($past(st_q.w_data, 2) & MASK_B))
		else $error("port B pin not updated by write");
	port_a_write_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		wr_a && st_q.w_strb == 2'h3 |=> ##1
		PORT_A_BUF_OFF_OUT == ($past(st_q.w_data, 2) & PAS_MASK_A))
		else $error("port A pin not updated by write");
	// ****************************************
	// Cover points
	// ****************************************
	wr_a_c: cover property (@(posedge SYS_CLK_IN) disable iff (RST_IN) wr_a);
	wr_b_c: cover property (@(posedge SYS_CLK_IN) disable iff (RST_IN) wr_b);
	bad_wr_c: cover property (@(posedge SYS_CLK_IN) disable iff (RST_IN) do_wr && !wr_a && !wr_b);
	rd_c: cover property (@(posedge SYS_CLK_IN) disable iff (RST_IN) S_AXI_ARREADY_OUT);
endmodule : pas_top

// File: tb/tb_top.sv
// Self-checking bench for the port analog select block, all three packages on one bus.
// Assumes pas_top and pas_pkg compiled first; drives its AXI4-Lite slave directly.
`timescale 1ns/1ps
module tb_top import pas_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] awa = 4'h0, ara = 4'h0, ws = 4'h0;
	logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic [31:0] wd = 32'h0, rd;
	logic awr, wr, bv, arr, rv;
	logic [1:0] br, rr;
	logic [15:0] pa, pb;
	logic [15:0] pb20, pb28;
	int bad_count = 0;
	int n_compared = 0;
	always #4 clk = ~clk;
	pas_top #(.PIN_COUNT(PAS_PINS_14)) u_dut (.SYS_CLK_IN(clk), .RST_IN(rst),
		.S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
		.S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(ws), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr),
		.S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bry),
		.S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
		.S_AXI_RDATA_OUT(rd), .S_AXI_RRESP_OUT(rr), .S_AXI_RVALID_OUT(rv),
		.S_AXI_RREADY_IN(rry), .PORT_A_BUF_OFF_OUT(pa), .PORT_B_BUF_OFF_OUT(pb));
	// Larger packages follow the same bus traffic; only their pin masks are judged
	pas_top #(.PIN_COUNT(PAS_PINS_20)) u_dut_20 (.SYS_CLK_IN(clk), .RST_IN(rst),
		.S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(),
		.S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(ws), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(),
		.S_AXI_BRESP_OUT(), .S_AXI_BVALID_OUT(), .S_AXI_BREADY_IN(bry),
		.S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(),
		.S_AXI_RDATA_OUT(), .S_AXI_RRESP_OUT(), .S_AXI_RVALID_OUT(),
		.S_AXI_RREADY_IN(rry), .PORT_A_BUF_OFF_OUT(), .PORT_B_BUF_OFF_OUT(pb20));
	pas_top #(.PIN_COUNT(PAS_PINS_28)) u_dut_28 (.SYS_CLK_IN(clk), .RST_IN(rst),
		.S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(),
		.S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(ws), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(),
		.S_AXI_BRESP_OUT(), .S_AXI_BVALID_OUT(), .S_AXI_BREADY_IN(bry),
		.S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(),
		.S_AXI_RDATA_OUT(), .S_AXI_RRESP_OUT(), .S_AXI_RVALID_OUT(),
		.S_AXI_RREADY_IN(rry), .PORT_A_BUF_OFF_OUT(), .PORT_B_BUF_OFF_OUT(pb28));
	// ****************
	// Checking and bus tasks
	// ****************
	task automatic report_and_stop;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic give_up;
		bad_count++;
		$display("BAD %0t bus wait ran out", $time);
		report_and_stop();
	endtask : give_up
	task automatic axi_write(input logic [3:0] a, input logic [15:0] d, input logic [1:0] s,
			input logic [1:0] er);
		logic aw_t, w_t, b_t;
		@(posedge clk);
		awa <= a;
		awv <= 1'b1;
		wd <= {16'h0000, d};
		ws <= {2'h0, s};
		wv <= 1'b1;
		bry <= 1'b1;
		for (int i = 0; i < 40; i++) begin
			@(negedge clk);
			aw_t = awv && awr;
			w_t = wv && wr;
			b_t = bv;
			if (b_t) chk({30'h0, br}, {30'h0, er});
			@(posedge clk);
			if (aw_t) awv <= 1'b0;
			if (w_t) wv <= 1'b0;
			if (b_t) begin
				bry <= 1'b0;
				return;
			end
		end
		give_up();
	endtask : axi_write
	task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ar_t, r_t;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		for (int i = 0; i < 40; i++) begin
			@(negedge clk);
			ar_t = arv && arr;
			r_t = rv;
			if (r_t) chk(rd, ed);
			if (r_t) chk({30'h0, rr}, {30'h0, er});
			@(posedge clk);
			if (ar_t) arv <= 1'b0;
			if (r_t) begin
				rry <= 1'b0;
				return;
			end
		end
		give_up();
	endtask : axi_read
	task automatic wr_rd(input logic [3:0] a, input logic [15:0] d, input logic [1:0] s,
			input logic [15:0] e);
		axi_write(a, d, s, PAS_RESP_OKAY);
		axi_read(a, {16'h0000, e}, PAS_RESP_OKAY);
		@(negedge clk);
		chk({16'h0000, (a == PAS_OFS_PORT_A) ? pa : pb}, {16'h0000, e});
	endtask : wr_rd
	// ****************
	// Scenarios
	// ****************
	task automatic scn_reset;
		chk({16'h0000, pa}, 32'h0000000F);
		chk({16'h0000, pb}, 32'h0000C010);
		chk({16'h0000, pb20}, 32'h0000F017);
		chk({16'h0000, pb28}, 32'h0000F01F);
		axi_read(PAS_OFS_PORT_A, 32'h0000000F, PAS_RESP_OKAY);
		axi_read(PAS_OFS_PORT_B, 32'h0000C010, PAS_RESP_OKAY);
	endtask : scn_reset
	task automatic scn_port_a;
		wr_rd(PAS_OFS_PORT_A, 16'hFFF0, 2'h3, 16'h0000);
		wr_rd(PAS_OFS_PORT_A, 16'hFFFF, 2'h3, 16'h000F);
		wr_rd(PAS_OFS_PORT_A, 16'h000A, 2'h3, 16'h000A);
	endtask : scn_port_a
	task automatic scn_port_b;
		wr_rd(PAS_OFS_PORT_B, 16'hFFFF, 2'h3, 16'hC010);
		chk({16'h0000, pb20}, 32'h0000F017);
		chk({16'h0000, pb28}, 32'h0000F01F);
		wr_rd(PAS_OFS_PORT_B, 16'h0000, 2'h1, 16'hC000);
		wr_rd(PAS_OFS_PORT_B, 16'h4FEF, 2'h3, 16'h4000);
		chk({16'h0000, pb20}, 32'h00004007);
		chk({16'h0000, pb28}, 32'h0000400F);
		wr_rd(PAS_OFS_PORT_B, 16'h3017, 2'h3, 16'h0010);
		chk({16'h0000, pb20}, 32'h00003017);
	endtask : scn_port_b
	task automatic scn_mid_reset;
		@(posedge clk);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		scn_reset();
	endtask : scn_mid_reset
	task automatic scn_unmapped;
		axi_write(4'h8, 16'h0000, 2'h3, PAS_RESP_SLVERR);
		axi_read(4'h8, 32'h00000000, PAS_RESP_SLVERR);
		axi_read(PAS_OFS_PORT_A, 32'h0000000A, PAS_RESP_OKAY);
	endtask : scn_unmapped
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		scn_reset();
		scn_port_a();
		scn_port_b();
		scn_unmapped();
		scn_mid_reset();
		report_and_stop();
	end
endmodule : tb_top
